/* File: rtl/sadc_pkg.sv */
package sadc_pkg;
  localparam int SADC_DATA_BITS = 18;
  localparam int SADC_PACK_BITS = 16;
  localparam int SADC_CNT_W = 6;
  localparam logic [SADC_CNT_W-1:0] SADC_NORM_LEN = 6'h12;
  localparam logic [SADC_CNT_W-1:0] SADC_PACK_LEN = 6'h20;
  localparam logic [SADC_DATA_BITS-1:0] SADC_RESULT_RST = 18'h00000;
  localparam int SADC_CONVERT_STROBE_DIV = 3;
  localparam int SADC_OSC_MIN_PULSES = 72;
  localparam real SADC_MAX_RATE_KHZ = 200.0;
  localparam real SADC_MCLK_MHZ = 100.0;
  localparam int SADC_MIN_STROBE_CYC = int'(SADC_MCLK_MHZ * 1000.0 / SADC_MAX_RATE_KHZ);
  typedef enum logic [1:0] {
    SADC_IDLE = 2'b00,
    SADC_MARK = 2'b01,
    SADC_SHIFT = 2'b10,
    SADC_APPEND = 2'b11
  } sadc_state_e;
endpackage

/* File: rtl/sadc_sync2.sv */
`timescale 1ns/1ps
module sadc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end
  assign o_sync = sync_reg;
endmodule

/* File: rtl/sadc_serial_port.sv */
`timescale 1ns/1ps
module sadc_serial_port #(
  parameter int DATA_BITS = 18,
  parameter int CONVERT_STROBE_DIV = 3
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_convert_strobe,
  input wire logic i_marker_polarity_select,
  input wire logic i_pair_pack_select,
  input wire logic i_transfer_bit_clock,
  input wire logic i_master_oscillator_in,
  input wire logic i_conversion_clock_in,
  input wire logic i_append_a,
  input wire logic i_append_b,
  input wire logic [DATA_BITS-1:0] i_result_a,
  input wire logic [DATA_BITS-1:0] i_result_b,
  output logic o_hold,
  output logic o_convert_strobe_start,
  output logic o_frame_marker,
  output logic o_result_serial_line_a,
  output logic o_result_serial_line_b,
  output logic o_conversion_clock_out,
  output logic o_convert_strobe_clk_tick
);
  import sadc_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [6:0] pins_s;
  sadc_sync2 #(.WIDTH(7)) u_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_convert_strobe, i_marker_polarity_select, i_pair_pack_select,
              i_transfer_bit_clock, i_master_oscillator_in, i_conversion_clock_in,
              i_append_a}),
    .o_sync(pins_s)
  );
  logic tagb_s;
  sadc_sync2 #(.WIDTH(1)) u_sync_b (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_append_b),
    .o_sync(tagb_s)
  );
  logic convert_strobe_s, pol_s, pack_s, transfer_bit_clock_s, osc_s, cclk_s, taga_s;
  assign {convert_strobe_s, pol_s, pack_s, transfer_bit_clock_s, osc_s, cclk_s, taga_s} = pins_s;

  logic convert_strobe_d_reg, transfer_bit_clock_d_reg, osc_d_reg, cclk_d_reg;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      // matches the synchroniser's reset level, so leaving reset makes no false fall
      convert_strobe_d_reg <= 1'b0;
      transfer_bit_clock_d_reg <= 1'b0;
      osc_d_reg <= 1'b0;
      cclk_d_reg <= 1'b0;
    end else begin
      convert_strobe_d_reg <= convert_strobe_s;
      transfer_bit_clock_d_reg <= transfer_bit_clock_s;
      osc_d_reg <= osc_s;
      cclk_d_reg <= cclk_s;
    end
  end
  logic convert_strobe_fall, transfer_bit_clock_rise, osc_rise, cclk_rise;
  assign convert_strobe_fall = convert_strobe_d_reg & ~convert_strobe_s;
  assign transfer_bit_clock_rise = ~transfer_bit_clock_d_reg & transfer_bit_clock_s;
  assign osc_rise = ~osc_d_reg & osc_s;
  assign cclk_rise = ~cclk_d_reg & cclk_s;

  // ----------------------------------------------------------------
  // conversion clock: oscillator divided down, fed back in externally
  // ----------------------------------------------------------------
  logic [1:0] div_reg;
  logic cko_reg;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      div_reg <= 2'h0;
      cko_reg <= 1'b0;
    end else if (osc_rise) begin
      // one third high so several converters see a common rising edge
      if (div_reg == 2'(CONVERT_STROBE_DIV - 1)) begin
        div_reg <= 2'h0;
      end else begin
        div_reg <= div_reg + 2'h1;
      end
      cko_reg <= (div_reg == 2'(CONVERT_STROBE_DIV - 1));
    end
  end
  assign o_conversion_clock_out = cko_reg;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_convert_strobe_clk_tick <= 1'b0;
    end else begin
      o_convert_strobe_clk_tick <= cclk_rise;
    end
  end

  // ----------------------------------------------------------------
  // hold and conversion start
  // ----------------------------------------------------------------
  logic [DATA_BITS-1:0] prev_a_reg, prev_b_reg;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_hold <= 1'b0;
      o_convert_strobe_start <= 1'b0;
      prev_a_reg <= SADC_RESULT_RST;
      prev_b_reg <= SADC_RESULT_RST;
    end else begin
      o_convert_strobe_start <= convert_strobe_fall;
      if (convert_strobe_fall) begin
        o_hold <= 1'b1;
        // latch the finished result; the new conversion is sent next frame
        prev_a_reg <= i_result_a;
        prev_b_reg <= i_result_b;
      end else if (!convert_strobe_s) begin
        o_hold <= 1'b1;
      end else begin
        o_hold <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer, advanced on transfer clock rising edges
  // ----------------------------------------------------------------
  sadc_state_e state_reg;
  logic start_pend_reg;
  logic [SADC_CNT_W-1:0] bit_reg;
  logic [DATA_BITS-1:0] sh_a_reg, sh_b_reg;
  logic pack_reg;
  logic [SADC_CNT_W-1:0] frame_len;
  assign frame_len = pack_reg ? SADC_PACK_LEN : SADC_NORM_LEN;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      start_pend_reg <= 1'b0;
    end else if (convert_strobe_fall) begin
      start_pend_reg <= 1'b1;
    end else if (transfer_bit_clock_rise) begin
      start_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_reg <= SADC_IDLE;
      bit_reg <= '0;
      sh_a_reg <= '0;
      sh_b_reg <= '0;
      pack_reg <= 1'b0;
    end else if (transfer_bit_clock_rise) begin
      if (start_pend_reg) begin
        // marker occupies exactly one bit clock, data follows
        state_reg <= SADC_MARK;
        pack_reg <= pack_s;
        bit_reg <= '0;
        if (pack_s) begin
          // channel A's top 16 bits, then channel B's top 16 bits
          sh_a_reg <= prev_a_reg;
          sh_b_reg <= prev_b_reg;
        end else begin
          sh_a_reg <= prev_a_reg;
          sh_b_reg <= prev_b_reg;
        end
      end else begin
        unique case (state_reg)
          SADC_IDLE: begin
            state_reg <= SADC_IDLE;
          end
          SADC_MARK: begin
            // the msb leaves on the rise that ends the marker
            state_reg <= SADC_SHIFT;
            bit_reg <= 6'h01;
            sh_a_reg <= {sh_a_reg[DATA_BITS-2:0], 1'b0};
            if (!pack_reg) begin
              sh_b_reg <= {sh_b_reg[DATA_BITS-2:0], 1'b0};
            end
          end
          SADC_SHIFT: begin
            if (bit_reg == frame_len - 6'h01) begin
              state_reg <= SADC_APPEND;
            end
            bit_reg <= bit_reg + 6'h01;
            if (pack_reg && bit_reg == 6'(SADC_PACK_BITS - 1)) begin
              sh_a_reg <= sh_b_reg;
            end else begin
              sh_a_reg <= {sh_a_reg[DATA_BITS-2:0], 1'b0};
            end
            // in pair-pack mode channel B waits unshifted until line A takes it over
            if (!pack_reg) begin
              sh_b_reg <= {sh_b_reg[DATA_BITS-2:0], 1'b0};
            end
          end
          SADC_APPEND: begin
            state_reg <= SADC_APPEND;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // output pins: serial lines updated on the transfer clock rising edge, marker on every clock
  // ----------------------------------------------------------------
  logic mark_on;
  assign mark_on = (state_reg == SADC_MARK);
  logic [1:0] settle_reg;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      settle_reg <= 2'h0;
    end else begin
      settle_reg <= {settle_reg[0], 1'b1};
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_frame_marker <= 1'b0;
    end else if (settle_reg[1]) begin
      // waits for the synchronised select, else a false marker follows reset
      // polarity follows the select pin live, even between frames
      o_frame_marker <= pol_s ? mark_on : ~mark_on;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_result_serial_line_a <= 1'b0;
      o_result_serial_line_b <= 1'b0;
    end else if (transfer_bit_clock_rise) begin
      if ((state_reg == SADC_MARK || state_reg == SADC_SHIFT) && !start_pend_reg) begin
        o_result_serial_line_a <= sh_a_reg[DATA_BITS-1];
        o_result_serial_line_b <= pack_reg ? tagb_s : sh_b_reg[DATA_BITS-1];
      end else begin
        // append bits fill the line after the result and while idle
        o_result_serial_line_a <= taga_s;
        o_result_serial_line_b <= tagb_s;
      end
    end
  end
endmodule

/* File: verification/sadc_port_monitor.sv */
`timescale 1ns/1ps
module sadc_port_monitor (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_convert_strobe,
  input wire logic i_marker_polarity_select,
  input wire logic i_conversion_clock_in,
  input wire logic o_hold,
  input wire logic o_convert_strobe_start,
  input wire logic o_frame_marker,
  input wire logic o_conversion_clock_out,
  input wire logic o_convert_strobe_clk_tick
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // --------
  // marker run length
  // --------
  // runs are ignored until the polarity pin has been steady, since the
  // inactive level briefly matches a freshly changed select
  logic [2:0] pol_age_reg;
  logic [4:0] act_cnt_reg;
  logic pol_last_reg;
  wire act = o_frame_marker == i_marker_polarity_select;
  wire pol_ok = pol_age_reg == 3'h7;
  always_ff @(posedge i_mclk) begin
    pol_last_reg <= i_marker_polarity_select;
    if (i_sys_rst || pol_last_reg != i_marker_polarity_select) pol_age_reg <= 3'h0;
    else if (!pol_ok) pol_age_reg <= pol_age_reg + 3'h1;
  end
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || !act) act_cnt_reg <= 5'h00;
    else if (act_cnt_reg != 5'h1F) act_cnt_reg <= act_cnt_reg + 5'h01;
  end
  sequence clk_hi_s;
    o_conversion_clock_out [*7];
  endsequence
  start_cause_a: assert property ($fell(i_convert_strobe) |-> ##[2:5] o_convert_strobe_start)
    else $error("no start pulse after strobe fall");
  start_pulse_a: assert property (o_convert_strobe_start |=> !o_convert_strobe_start)
    else $error("start pulse longer than one cycle");
  hold_on_a: assert property (o_convert_strobe_start |-> ##[0:1] o_hold)
    else $error("sampler not held at start");
  hold_release_a: assert property (i_convert_strobe [*5] |-> !o_hold)
    else $error("hold stays after strobe high");
  marker_max_a: assert property (pol_ok |-> act_cnt_reg <= 5'h0E)
    else $error("marker active too long");
  marker_min_a: assert property ($fell(act) && pol_ok |-> act_cnt_reg >= 5'h0B)
    else $error("marker shorter than one bit clock");
  tick_cause_a: assert property ($rose(i_conversion_clock_in) |-> ##[2:5] o_convert_strobe_clk_tick)
    else $error("no tick after conversion clock rise");
  tick_pulse_a: assert property (o_convert_strobe_clk_tick |=> !o_convert_strobe_clk_tick)
    else $error("tick longer than one cycle");
  conversion_clock_out_high_a: assert property ($rose(o_conversion_clock_out) |-> clk_hi_s ##[1:3] !o_conversion_clock_out)
    else $error("conversion clock high phase wrong");
  conversion_clock_out_low_a: assert property ($fell(o_conversion_clock_out) |-> !o_conversion_clock_out [*8])
    else $error("conversion clock low phase short");
endmodule
bind sadc_serial_port sadc_port_monitor mon_u (.i_mclk, .i_sys_rst, .i_convert_strobe,
  .i_marker_polarity_select, .i_conversion_clock_in, .o_hold, .o_convert_strobe_start, .o_frame_marker,
  .o_conversion_clock_out, .o_convert_strobe_clk_tick);

/* File: verification/sadc_dsp_model.sv */
`timescale 1ns/1ps
module sadc_dsp_model (
  input wire logic i_frame_marker,
  input wire logic i_marker_polarity_select,
  input wire logic i_line_a,
  input wire logic i_line_b,
  output logic o_bit_clock,
  output logic [35:0] o_word_a,
  output logic [35:0] o_word_b
);
  int bit_cnt = 36;
  initial begin
    o_bit_clock = 1'b0;
    #2;
    forever #62.5 o_bit_clock = ~o_bit_clock;
  end
  // sample on the falling edge, half a bit after the port launched on the rise
  always @(negedge o_bit_clock) begin
    if (i_frame_marker == i_marker_polarity_select) bit_cnt = 0;
    else if (bit_cnt < 36) begin
      o_word_a = {o_word_a[34:0], i_line_a};
      o_word_b = {o_word_b[34:0], i_line_b};
      bit_cnt++;
    end
  end
endmodule

/* File: verification/test_sampling_adc_serial_port.sv */
`timescale 1ns/1ps
module test_sampling_adc_serial_port;
  import sadc_pkg::*;
  logic i_mclk, i_sys_rst, i_convert_strobe, i_marker_polarity_select, i_pair_pack_select;
  logic i_master_oscillator_in, i_append_a, i_append_b;
  logic [SADC_DATA_BITS-1:0] i_result_a, i_result_b;
  wire logic transfer_bit_clock, clk_out, line_a, line_b, marker;
  logic [35:0] word_a, word_b;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  sadc_serial_port dut_u (.i_mclk, .i_sys_rst, .i_convert_strobe, .i_marker_polarity_select,
    .i_pair_pack_select, .i_transfer_bit_clock(transfer_bit_clock), .i_master_oscillator_in,
    .i_conversion_clock_in(clk_out), .i_append_a, .i_append_b, .i_result_a, .i_result_b,
    .o_hold(), .o_convert_strobe_start(), .o_frame_marker(marker), .o_result_serial_line_a(line_a),
    .o_result_serial_line_b(line_b), .o_conversion_clock_out(clk_out), .o_convert_strobe_clk_tick());
  sadc_dsp_model dsp_u (.i_frame_marker(marker), .i_marker_polarity_select, .i_line_a(line_a),
    .i_line_b(line_b), .o_bit_clock(transfer_bit_clock), .o_word_a(word_a), .o_word_b(word_b));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    i_master_oscillator_in = 1'b0;
    #3;
    forever #40 i_master_oscillator_in = ~i_master_oscillator_in;
  end
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string name, input logic [35:0] exp, input logic [35:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // --------
  // one conversion period
  // --------
  // 700 cycles keeps clear of 500 cycles, 72 oscillator pulses and 40 bit clocks
  task automatic frame(input logic [17:0] ra, input logic [17:0] rb);
    @(negedge i_mclk);
    i_convert_strobe = 1'b0;
    repeat (20) @(negedge i_mclk);
    i_convert_strobe = 1'b1;
    // this conversion's result appears now and leaves with the next strobe
    i_result_a = ra;
    i_result_b = rb;
    repeat (700) @(negedge i_mclk);
  endtask
  task automatic sc_normal();
    i_marker_polarity_select = 1'b1;
    i_pair_pack_select = 1'b0;
    i_append_a = 1'b1;
    i_append_b = 1'b0;
    frame(18'h20001, 18'h1FFFE);
    frame(18'h00000, 18'h00000);
    check("line_a", {18'h20001, 18'h3FFFF}, word_a);
    check("line_b", {18'h1FFFE, 18'h00000}, word_b);
  endtask
  task automatic sc_pack();
    logic [17:0] pa = 18'h2AAA9;
    logic [17:0] pb = 18'h15557;
    i_marker_polarity_select = 1'b0;
    i_pair_pack_select = 1'b1;
    i_append_a = 1'b1;
    i_append_b = 1'b0;
    frame(pa, pb);
    frame(18'h00000, 18'h00000);
    check("pack_a", {pa[17:2], pb[17:2], 4'hF}, word_a);
    check("pack_b", 36'h000000000, word_b);
  endtask
  initial begin
    i_sys_rst = 1'b1;
    i_convert_strobe = 1'b1;
    i_marker_polarity_select = 1'b1;
    i_pair_pack_select = 1'b0;
    i_append_a = 1'b0;
    i_append_b = 1'b0;
    i_result_a = SADC_RESULT_RST;
    i_result_b = SADC_RESULT_RST;
    repeat (4) @(negedge i_mclk);
    i_sys_rst = 1'b0;
    repeat (4) @(negedge i_mclk);
    sc_normal();
    sc_pack();
    end_of_test();
  end
endmodule
